/* verilog/tmr8_cfg.svh */
`ifndef TMR8_CFG_SVH
`define TMR8_CFG_SVH
// register byte addresses
`define TMR8_CTRL_A_OFF   12'h030
`define TMR8_CTRL_B_OFF   12'h034
`define TMR8_CNT_OFF      12'h038
`define TMR8_CMPA_OFF     12'h03C
`define TMR8_CMPB_OFF     12'h040
`define TMR8_STAT_OFF     12'h044
`define TMR8_MASK_OFF     12'h048
`define TMR8_DIR_OFF      12'h04C
// control a field positions
`define TMR8_COMA_MSB     7
`define TMR8_COMA_LSB     6
`define TMR8_COMB_MSB     5
`define TMR8_COMB_LSB     4
`define TMR8_WGM_LO_MSB   1
`define TMR8_WGM_LO_LSB   0
// control b field positions
`define TMR8_WGM_MSB_POS  3
// status and mask bits
`define TMR8_OVF_BIT      0
`define TMR8_CFA_BIT      1
`define TMR8_CFB_BIT      2
// reset values and counter limits
`define TMR8_CTRL_RST     8'h00
`define TMR8_MAX          8'hFF
`define TMR8_BOTTOM       8'h00
`endif

/* verilog/tmr8_pkg.sv */
package tmr8_pkg;
    // decoded waveform behaviour
    typedef enum logic [2:0] {
        TMR8_NORMAL,
        TMR8_CTC,
        TMR8_FAST,
        TMR8_PHASE,
        TMR8_RSVD
    } tmr8_kind_e;
    // decoded mode: kind and whether top is compare a
    typedef struct packed {
        tmr8_kind_e kind;
        logic       top_from_a;
    } tmr8_mode_s;
    // per-channel compare output: level and pin override
    typedef struct packed {
        logic level;
        logic own_pin;
    } tmr8_wave_s;
endpackage

/* verilog/tmr8_wave_ctrl.sv */
`timescale 1ns/1ps
`include "tmr8_cfg.svh"
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - all logic on pclk, tick only enables
// - nonzero output mode takes pin, if output
// - non-pwm a: off, toggle, clear, set
// - pwm a code 01 toggles only with msb
// - fast a: clear/set on match, opposite bottom
// - fast, compare equals top: only bottom action
// - phase a: up-match and down-match opposite
// - phase, compare equals top: action at top
// - non-pwm b: off, toggle, clear, set
// - fast b: 01 reserved, 10/11 as a
// - phase b: 01 reserved, 10/11 as a
// - control a bits 3 and 2 read zero
// - mode = control b bit plus two low
// - mode table decodes kind and top source
// - normal/ctc overflow on max tick
module tmr8_wave_ctrl
    import tmr8_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // prescaled tick, same clock domain
    input  wire logic        timer_tick,
    // compare output pins
    output logic             wave_out_a,
    output logic             wave_out_a_oe_n,
    output logic             wave_out_b,
    output logic             wave_out_b_oe_n,
    // interrupt
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    // mode number to kind and top source
    function automatic tmr8_mode_s decode_mode(input logic [2:0] m);
        tmr8_mode_s r;
        r.top_from_a = 1'b0;
        r.kind       = TMR8_RSVD;
        unique case (m)
            3'h0: r.kind = TMR8_NORMAL;
            3'h1: r.kind = TMR8_PHASE;
            3'h2: begin
                r.kind       = TMR8_CTC;
                r.top_from_a = 1'b1;
            end
            3'h3: r.kind = TMR8_FAST;
            3'h5: begin
                r.kind       = TMR8_PHASE;
                r.top_from_a = 1'b1;
            end
            3'h7: begin
                r.kind       = TMR8_FAST;
                r.top_from_a = 1'b1;
            end
            default: r.kind = TMR8_RSVD;
        endcase
        return r;
    endfunction

    // next output level for one channel
    function automatic logic wave_next(
        input logic       cur,
        input logic [1:0] com,
        input logic       chan_a,
        input logic       wgm_msb,
        input tmr8_kind_e kind,
        input logic       match,
        input logic       at_top,
        input logic       at_bottom,
        input logic       up,
        input logic       cmp_is_top
    );
        logic nx;
        logic hit;
        nx  = cur;
        hit = match;
        unique case (kind)
            TMR8_NORMAL, TMR8_CTC: begin
                if (hit) begin
                    unique case (com)
                        2'b01:   nx = ~cur;
                        2'b10:   nx = 1'b0;
                        2'b11:   nx = 1'b1;
                        default: nx = cur;
                    endcase
                end
            end
            TMR8_FAST: begin
                if (com == 2'b01) begin
                    if (chan_a && wgm_msb && hit) begin
                        nx = ~cur;
                    end
                end else if (com[1]) begin
                    if (cmp_is_top) begin
                        hit = 1'b0;
                    end
                    if (at_bottom) begin
                        nx = ~com[0];
                    end else if (hit) begin
                        nx = com[0];
                    end
                end
            end
            TMR8_PHASE: begin
                if (com == 2'b01) begin
                    if (chan_a && wgm_msb && hit) begin
                        nx = ~cur;
                    end
                end else if (com[1]) begin
                    if (cmp_is_top) begin
                        if (at_top) begin
                            nx = ~com[0];
                        end
                    end else if (hit) begin
                        nx = up ? com[0] : ~com[0];
                    end
                end
            end
            default: nx = cur;
        endcase
        return nx;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [7:0]  ctrl_a_q,   ctrl_a_d;    // output modes and low mode bits
    logic        wgm_msb_q,  wgm_msb_d;   // mode msb in control b
    logic [7:0]  cnt_q,      cnt_d;       // counter value
    logic        up_q,       up_d;        // phase mode direction
    logic [7:0]  cmpa_q,     cmpa_d;      // active compare a
    logic [7:0]  cmpb_q,     cmpb_d;      // active compare b
    logic [7:0]  cmpa_buf_q, cmpa_buf_d;  // software compare a
    logic [7:0]  cmpb_buf_q, cmpb_buf_d;  // software compare b
    logic [2:0]  stat_q,     stat_d;      // sticky event flags
    logic [2:0]  mask_q,     mask_d;      // interrupt enables
    logic [1:0]  dir_q,      dir_d;       // pin directions, 1 = output
    logic        wa_q,       wa_d;        // channel a level
    logic        wb_q,       wb_d;        // channel b level
    logic        wa_oen_q,   wa_oen_d;    // channel a enable, low drives
    logic        wb_oen_q,   wb_oen_d;    // channel b enable, low drives
    logic [31:0] prdata_q,   prdata_d;    // read data
    logic        pready_q,   pready_d;    // access answer
    logic        pslverr_q,  pslverr_d;   // unmapped answer
    logic        irq_q,      irq_d;       // interrupt level

    // combinational decode
    logic [2:0]  wgm;        // full mode number
    tmr8_mode_s  mode;       // decoded mode
    logic [7:0]  top;        // current top
    logic        at_top;     // counter at top
    logic        at_bottom;  // fast restart from top to bottom
    logic        wr;         // write access
    logic        rd;         // read access
    logic        mapped;     // address hits a register
    logic        cnt_wr;     // software writes counter
    logic        match_a;    // compare a match on tick
    logic        match_b;    // compare b match on tick
    logic [2:0]  ev;         // events this cycle

    assign wgm  = {wgm_msb_q, ctrl_a_q[`TMR8_WGM_LO_MSB:`TMR8_WGM_LO_LSB]};
    assign mode = decode_mode(wgm);
    assign top  = mode.top_from_a ? cmpa_q : `TMR8_MAX;
    assign at_top = (cnt_q == top);
    assign at_bottom = timer_tick && (mode.kind == TMR8_FAST) && at_top;
    assign wr = psel && penable && pwrite && !pready_q;
    assign rd = psel && penable && !pwrite && !pready_q;
    assign cnt_wr = wr && (paddr == `TMR8_CNT_OFF) && pstrb[0];
    assign match_a = timer_tick && (cnt_q == cmpa_q);
    assign match_b = timer_tick && (cnt_q == cmpb_q);

    // address decode
    always_comb begin
        unique case (paddr)
            `TMR8_CTRL_A_OFF, `TMR8_CTRL_B_OFF, `TMR8_CNT_OFF, `TMR8_CMPA_OFF,
            `TMR8_CMPB_OFF, `TMR8_STAT_OFF, `TMR8_MASK_OFF, `TMR8_DIR_OFF: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // counter, buffers and events

    always_comb begin
        cnt_d      = cnt_q;
        up_d       = up_q;
        cmpa_d     = cmpa_q;
        cmpb_d     = cmpb_q;
        cmpa_buf_d = cmpa_buf_q;
        cmpb_buf_d = cmpb_buf_q;
        ev         = 3'h0;
        // counting only on ticks
        if (timer_tick) begin
            unique case (mode.kind)
                TMR8_NORMAL: begin
                    cnt_d = 8'(cnt_q + 8'h01);
                    ev[`TMR8_OVF_BIT] = (cnt_q == `TMR8_MAX);
                end
                TMR8_CTC: begin
                    cnt_d = at_top ? `TMR8_BOTTOM : 8'(cnt_q + 8'h01);
                    ev[`TMR8_OVF_BIT] = (cnt_q == `TMR8_MAX);
                end
                TMR8_FAST: begin
                    cnt_d = at_top ? `TMR8_BOTTOM : 8'(cnt_q + 8'h01);
                    ev[`TMR8_OVF_BIT] = mode.top_from_a ? at_top : (cnt_q == `TMR8_MAX);
                end
                TMR8_PHASE: begin
                    if (up_q) begin
                        if (at_top) begin
                            up_d  = 1'b0;
                            cnt_d = 8'(cnt_q - 8'h01);
                        end else begin
                            cnt_d = 8'(cnt_q + 8'h01);
                        end
                    end else if (cnt_q == `TMR8_BOTTOM) begin
                        up_d  = 1'b1;
                        cnt_d = 8'(cnt_q + 8'h01);
                        ev[`TMR8_OVF_BIT] = 1'b1;
                    end else begin
                        cnt_d = 8'(cnt_q - 8'h01);
                    end
                end
                default: cnt_d = cnt_q;
            endcase
            ev[`TMR8_CFA_BIT] = match_a;
            ev[`TMR8_CFB_BIT] = match_b;
        end
        // compare buffer takeover
        if (mode.kind == TMR8_NORMAL || mode.kind == TMR8_CTC) begin
            cmpa_d = cmpa_buf_q;
            cmpb_d = cmpb_buf_q;
        end else if ((mode.kind == TMR8_PHASE && timer_tick && at_top) || at_bottom) begin
            cmpa_d = cmpa_buf_q;
            cmpb_d = cmpb_buf_q;
        end
        // software writes
        if (cnt_wr) begin
            cnt_d = pwdata[7:0];
        end
        if (wr && pstrb[0] && paddr == `TMR8_CMPA_OFF) begin
            cmpa_buf_d = pwdata[7:0];
        end
        if (wr && pstrb[0] && paddr == `TMR8_CMPB_OFF) begin
            cmpb_buf_d = pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control, flags, pins and bus answer

    always_comb begin
        ctrl_a_d  = ctrl_a_q;
        wgm_msb_d = wgm_msb_q;
        mask_d    = mask_q;
        dir_d     = dir_q;
        stat_d    = stat_q;
        prdata_d  = 32'h0000_0000;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        // writes, low byte lane only
        if (wr && pstrb[0]) begin
            unique case (paddr)
                `TMR8_CTRL_A_OFF: ctrl_a_d = pwdata[7:0] & 8'hF3;
                `TMR8_CTRL_B_OFF: wgm_msb_d = pwdata[`TMR8_WGM_MSB_POS];
                `TMR8_STAT_OFF:   stat_d = stat_q & ~pwdata[2:0];
                `TMR8_MASK_OFF:   mask_d = pwdata[2:0];
                `TMR8_DIR_OFF:    dir_d = pwdata[1:0];
                default:          stat_d = stat_q;
            endcase
        end
        // set wins over clear
        stat_d = stat_d | ev;
        // read mux
        if (rd) begin
            unique case (paddr)
                `TMR8_CTRL_A_OFF: prdata_d = {24'h0, ctrl_a_q & 8'hF3};
                `TMR8_CTRL_B_OFF: prdata_d = {28'h0, wgm_msb_q, 3'h0};
                `TMR8_CNT_OFF:    prdata_d = {24'h0, cnt_q};
                `TMR8_CMPA_OFF:   prdata_d = {24'h0, cmpa_buf_q};
                `TMR8_CMPB_OFF:   prdata_d = {24'h0, cmpb_buf_q};
                `TMR8_STAT_OFF:   prdata_d = {29'h0, stat_q};
                `TMR8_MASK_OFF:   prdata_d = {29'h0, mask_q};
                `TMR8_DIR_OFF:    prdata_d = {30'h0, dir_q};
                default:          prdata_d = 32'h0000_0000;
            endcase
        end
        if (psel && penable && !pready_q) begin
            pready_d  = 1'b1;
            pslverr_d = !mapped;
        end
        irq_d = |(stat_d & mask_d);
    end

    // waveform levels and pin override
    always_comb begin
        wa_d = wave_next(wa_q, ctrl_a_q[`TMR8_COMA_MSB:`TMR8_COMA_LSB], 1'b1, wgm_msb_q, mode.kind,
                         match_a && !cnt_wr, timer_tick && at_top, at_bottom, up_q, cmpa_q == top);
        wb_d = wave_next(wb_q, ctrl_a_q[`TMR8_COMB_MSB:`TMR8_COMB_LSB], 1'b0, wgm_msb_q, mode.kind,
                         match_b && !cnt_wr, timer_tick && at_top, at_bottom, up_q, cmpb_q == top);
        // driven only when mode nonzero and direction is output
        wa_oen_d = !((|ctrl_a_q[`TMR8_COMA_MSB:`TMR8_COMA_LSB]) && dir_q[0]);
        wb_oen_d = !((|ctrl_a_q[`TMR8_COMB_MSB:`TMR8_COMB_LSB]) && dir_q[1]);
    end

    // register all state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_a_q   <= `TMR8_CTRL_RST;
            wgm_msb_q  <= 1'b0;
            cnt_q      <= `TMR8_BOTTOM;
            up_q       <= 1'b1;
            cmpa_q     <= 8'h00;
            cmpb_q     <= 8'h00;
            cmpa_buf_q <= 8'h00;
            cmpb_buf_q <= 8'h00;
            stat_q     <= 3'h0;
            mask_q     <= 3'h0;
            dir_q      <= 2'h0;
            wa_q       <= 1'b0;
            wb_q       <= 1'b0;
            wa_oen_q   <= 1'b1;
            wb_oen_q   <= 1'b1;
            prdata_q   <= 32'h0000_0000;
            pready_q   <= 1'b0;
            pslverr_q  <= 1'b0;
            irq_q      <= 1'b0;
        end else begin
            ctrl_a_q   <= ctrl_a_d;
            wgm_msb_q  <= wgm_msb_d;
            cnt_q      <= cnt_d;
            up_q       <= up_d;
            cmpa_q     <= cmpa_d;
            cmpb_q     <= cmpb_d;
            cmpa_buf_q <= cmpa_buf_d;
            cmpb_buf_q <= cmpb_buf_d;
            stat_q     <= stat_d;
            mask_q     <= mask_d;
            dir_q      <= dir_d;
            wa_q       <= wa_d;
            wb_q       <= wb_d;
            wa_oen_q   <= wa_oen_d;
            wb_oen_q   <= wb_oen_d;
            prdata_q   <= prdata_d;
            pready_q   <= pready_d;
            pslverr_q  <= pslverr_d;
            irq_q      <= irq_d;
        end
    end

    // outputs straight from flops
    assign prdata          = prdata_q;
    assign pready          = pready_q;
    assign pslverr         = pslverr_q;
    assign wave_out_a      = wa_q;
    assign wave_out_a_oe_n = wa_oen_q;
    assign wave_out_b      = wb_q;
    assign wave_out_b_oe_n = wb_oen_q;
    assign irq             = irq_q;

endmodule

/* verification/tmr8_wave_ctrl_properties.sv */
`timescale 1ns/1ps
////////////////////////////////////////
// port checks of the timer wave control
module tmr8_wave_ctrl_properties (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // timer and pins
    input wire logic        timer_tick,
    input wire logic        wave_out_a,
    input wire logic        wave_out_a_oe_n,
    input wire logic        wave_out_b,
    input wire logic        wave_out_b_oe_n,
    input wire logic        irq
);
    // one domain for all checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////
    // answer comes one cycle into access
    a_ready_one_wait: assert property (psel && $rose(penable) |=> pready)
        else $error("pready not one cycle after access start");
    // answer stands one cycle
    a_ready_one_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    // read data zero outside answer
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero while idle");
    // places outside the map refused
    a_unmapped_err: assert property (pready && (paddr < 12'h030 || paddr > 12'h04C) |-> pslverr)
        else $error("no pslverr for unmapped place");
    // control reserved bits read zero
    a_ctrl_rsvd_zero: assert property (
        pready && !pwrite && paddr == 12'h030 |-> prdata[3:2] == 2'b00 && !pslverr)
        else $error("control reserved bits not zero");
    // levels move only on a tick
    a_wave_on_tick: assert property (
        $changed(wave_out_a) || $changed(wave_out_b) |-> $past(timer_tick))
        else $error("wave level moved without tick");
    // pin drive follows a register write
    a_oe_a_on_write: assert property (
        $changed(wave_out_a_oe_n) |-> pready || $past(pready))
        else $error("pin a drive changed without write");
    a_oe_b_on_write: assert property (
        $changed(wave_out_b_oe_n) |-> pready || $past(pready))
        else $error("pin b drive changed without write");
    // pins released, irq low out of reset
    a_reset_idle: assert property ($rose(presetn) |-> wave_out_a_oe_n && wave_out_b_oe_n && !irq)
        else $error("pins or irq active after reset");
endmodule
bind tmr8_wave_ctrl tmr8_wave_ctrl_properties u_props (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .timer_tick, .wave_out_a, .wave_out_a_oe_n, .wave_out_b, .wave_out_b_oe_n, .irq
);

/* verification/tb_timer8_wave_output_control.sv */
`timescale 1ns/1ps
`include "tmr8_cfg.svh"
module tb_timer8_wave_output_control;
    // register places
    localparam logic [11:0] ca = `TMR8_CTRL_A_OFF;
    localparam logic [11:0] cb = `TMR8_CTRL_B_OFF;
    localparam logic [11:0] cn = `TMR8_CNT_OFF;
    localparam logic [11:0] pa = `TMR8_CMPA_OFF;
    localparam logic [11:0] pb = `TMR8_CMPB_OFF;
    localparam logic [11:0] st = `TMR8_STAT_OFF;
    localparam logic [11:0] mk = `TMR8_MASK_OFF;
    localparam logic [11:0] dr = `TMR8_DIR_OFF;
    // expected apb answer
    typedef struct packed {
        logic [31:0] data;
        logic [31:0] mask;
        logic        err;
    } tmr8_note_s;
    // design inputs, idle at time zero
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic        timer_tick = 1'b0;
    // design outputs
    logic [31:0] prdata;
    logic        pready, pslverr, wave_out_a, wave_out_a_oe_n, wave_out_b, wave_out_b_oe_n, irq;
    // bench state
    tmr8_note_s  notes[$];
    tmr8_note_s  note;
    int          mismatches = 0, n_compared = 0, r;
    logic        wa0, wb0;      // levels before a toggle scenario
    ////////////////////////////////////////
    tmr8_wave_ctrl dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .timer_tick, .wave_out_a, .wave_out_a_oe_n, .wave_out_b, .wave_out_b_oe_n, .irq
    );
    // 100 ns clock
    always #50 pclk = ~pclk;
    ////////////////////////////////////////
    // counted comparison
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one transfer; answer noted for the monitor
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
                       input logic e);
        int n;
        n = 0;
        notes.push_back('{d, m, e});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        chk("pready wait", 32'h2, 32'(n));
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, 32'h0, 1'b0);
    endtask
    // upper bytes must read zero
    task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [7:0] m);
        apb(1'b0, a, {24'h0, d}, {24'hFF_FFFF, m}, 1'b0);
    endtask
    // n back-to-back ticks, then a quiet edge
    task automatic ticks(input int n);
        repeat (n) begin
            timer_tick <= 1'b1;
            @(posedge pclk);
        end
        timer_tick <= 1'b0;
        @(posedge pclk);
    endtask
    // monitor: oldest note against each answer
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            note = notes.pop_front();
            chk("prdata", note.data & note.mask, prdata & note.mask);
            chk("pslverr", 32'(note.err), 32'(pslverr));
        end
    end
    // verdict and end of run
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // watchdog, well past the expected run
    initial begin
        repeat (40000) @(posedge pclk);
        mismatches++;
        $display("Error watchdog expected finish seen hang");
        summarize();
    end
    ////////////////////////////////////////
    initial begin
        r = $urandom(77668);
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset value, reserved bits, unmapped place, pin drive
        rd(ca, `TMR8_CTRL_RST, 8'hFF);
        apb(1'b0, 12'h100, 32'h0, 32'hFFFF_FFFF, 1'b1);
        wr(ca, 8'hFF);
        rd(ca, 8'hF3, 8'hFF);
        wr(cb, 8'h08);
        rd(cb, 8'h08, 8'h08);
        wr(cb, 8'h00);
        chk("wave_out_a_oe_n", 32'h1, 32'(wave_out_a_oe_n));
        wr(dr, 8'h03);
        chk("wave_out_a_oe_n", 32'h0, 32'(wave_out_a_oe_n));
        chk("wave_out_b_oe_n", 32'h0, 32'(wave_out_b_oe_n));
        $display("test registers done");
        // normal mode: set, clear, toggle on both channels
        for (int c = 3; c >= 1; c--) begin
            r = 20 + $urandom % 150;
            wr(ca, {c[1:0], c[1:0], 4'h0});
            wr(pa, r[7:0]);
            wr(pb, r[7:0]);
            wr(cn, 8'h00);
            ticks(r + 3);
            chk("wave_out_a", 32'(c != 2), 32'(wave_out_a));
            chk("wave_out_b", 32'(c != 2), 32'(wave_out_b));
        end
        // overflow on wrap, irq raise, mask, clear
        wr(st, 8'h07);
        wr(mk, 8'h01);
        wr(cn, 8'hFD);
        ticks(1);
        rd(st, 8'h00, 8'h01);
        ticks(2);
        rd(st, 8'h01, 8'h01);
        chk("irq", 32'h1, 32'(irq));
        wr(mk, 8'h00);
        chk("irq", 32'h0, 32'(irq));
        wr(mk, 8'h01);
        wr(st, 8'h01);
        chk("irq", 32'h0, 32'(irq));
        // clear-on-match wraps at compare a
        r = 20 + $urandom % 150;
        wr(ca, 8'h02);
        wr(pa, r[7:0]);
        wr(cn, 8'h00);
        ticks(r + 3);
        rd(cn, 8'h02, 8'hFF);
        $display("test normal modes done");
        // fast pwm: level after match, then after bottom
        for (int c = 2; c <= 3; c++) begin
            r = 20 + $urandom % 150;
            wr(ca, 8'h00);
            wr(pa, r[7:0]);
            wr(ca, {c[1:0], 6'h03});
            wr(cn, 8'h00);
            ticks(r + 3);
            chk("wave_out_a", 32'(c == 3), 32'(wave_out_a));
            ticks(255 - r);
            chk("wave_out_a", 32'(c == 2), 32'(wave_out_a));
        end
        // compare at top: steady high, no glitch
        wr(ca, 8'h00);
        wr(pa, 8'hFF);
        wr(ca, 8'h83);
        ticks(260);
        for (int i = 0; i < 256; i++) begin
            ticks(1);
            chk("wave_out_a", 32'h1, 32'(wave_out_a));
        end
        // code 01: a toggles with mode msb, b reserved; mode 7 overflow at top
        r = 20 + $urandom % 150;
        wr(ca, 8'h00);
        wr(pa, r[7:0]);
        wr(pb, r[7:0]);
        wr(cb, 8'h08);
        wr(ca, 8'h53);
        wr(cn, 8'h00);
        wr(st, 8'h07);
        wa0 = wave_out_a;
        wb0 = wave_out_b;
        ticks(r + 1);
        chk("wave_out_a", 32'(!wa0), 32'(wave_out_a));
        chk("wave_out_b", 32'(wb0), 32'(wave_out_b));
        rd(st, 8'h01, 8'h01);
        // second reset, then phase correct up and down
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        r = 20 + $urandom % 150;
        wr(pa, r[7:0]);
        wr(pb, r[7:0]);
        wr(ca, 8'hE1);
        ticks(r + 3);
        chk("wave_out_a", 32'h1, 32'(wave_out_a));
        chk("wave_out_b", 32'h0, 32'(wave_out_b));
        ticks(510 - 2 * r);
        chk("wave_out_a", 32'h0, 32'(wave_out_a));
        chk("wave_out_b", 32'h1, 32'(wave_out_b));
        $display("test pwm modes done");
        summarize();
    end
endmodule
